/* bench/lfs_remote_port.sv */
// Behavioural remote port that feeds decoded characters to the receiver.
// Assumes its tasks are called right after a rising mclk edge.
`default_nettype none
module lfs_remote_port (
  input wire logic mclk,
  output logic rxStb = 1'b0,
  output logic rxSpecial = 1'b0,
  output logic [7:0] rxChar = 8'h00,
  output logic rxCrcGood = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic putc(input logic sp, input logic [7:0] ch, input logic crc);
    rxStb <= 1'b1;
    rxSpecial <= sp;
    rxChar <= ch;
    rxCrcGood <= crc;
    @(posedge mclk);
  endtask
  // Idle lines toggle so that a stale character is never read as a fresh one.
  task automatic rest();
    rxStb <= 1'b0;
    rxChar <= ~rxChar;
    repeat (3) @(posedge mclk);
  endtask
  // Only data, NUL and FLAG are sent here, so pairs and idle spacing hold.
  task automatic frame(input logic [7:0] ctl, input int len, input logic crc);
    putc(1'b0, ctl, 1'b0);
    putc(1'b1, 8'(lfs_pkg::K_NUL), 1'b0);
    for (int i = 1; i < len; i++) putc(1'b0, 8'(i), 1'b0);
    putc(1'b1, 8'(lfs_pkg::K_FLAG), crc);
  endtask
endmodule
`default_nettype wire

/* bench/link_frame_sequencing_tb.sv */
// Self-checking bench: register access, received frames and transmit monitoring.
// Assumes the remote port model drives the receive stream.
`default_nettype none
module link_frame_sequencing_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, nrst = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, q, eStat;
  logic ack_o, rxStb, rxSpecial, rxCrcGood, txStb = 1'b0, txSpecial = 1'b0;
  logic [7:0] rxChar, txChar = 8'h00;
  logic [1:0] txFsn;
  logic [2:0] erpCode, lastErp = 3'h0;
  logic txCtlOk, txPrivOk, txAppOk, erpReq, ackReq, frameAccept, frameDiscard, fwdOk;
  logic linkResetRx, totalReset, absoluteReset, postReq;
  int failures = 0, cmp_count = 0, nAcc = 0, nLrst = 0, nTot = 0;
  int nAck = 0, nFwd = 0, nDis = 0, nAbs = 0, nPost = 0;
  logic [7:0] ctlTab [4] = '{8'h0a, 8'h06, 8'h09, 8'h02};
  logic [2:0] okTab [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
  logic [7:0] eCtl [4] = '{8'h06, 8'h00, 8'h0e, 8'h02};
  int eLen [4] = '{6, 6, 6, 5};
  logic [2:0] eCode [4] = '{lfs_pkg::E_REJ, lfs_pkg::E_SEQ, lfs_pkg::E_REJ, lfs_pkg::E_PROTO};
  always #5 mclk = ~mclk;
  lfs_framer i_dut (.mclk, .nrst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rxStb, .rxSpecial,
    .rxChar, .rxCrcGood, .txStb, .txSpecial, .txChar, .txFsn, .txCtlOk, .txPrivOk, .txAppOk, .erpReq, .erpCode,
    .ackReq, .frameAccept, .frameDiscard, .fwdOk, .linkResetRx, .totalReset, .absoluteReset, .postReq);
  lfs_remote_port i_peer (.mclk, .rxStb, .rxSpecial, .rxChar, .rxCrcGood);
  always @(posedge mclk) begin
    if (frameAccept === 1'b1) nAcc++;
    if (ackReq === 1'b1) nAck++;
    if (fwdOk === 1'b1) nFwd++;
    if (frameDiscard === 1'b1) nDis++;
    if (linkResetRx === 1'b1) nLrst++;
    if (totalReset === 1'b1) nTot++;
    if (absoluteReset === 1'b1) nAbs++;
    if (postReq === 1'b1) nPost++;
    if (erpReq === 1'b1) lastErp <= erpCode;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // The wait has no limit of its own; only the watchdog ends a hung access.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge mclk);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic tx(input logic sp, input logic [7:0] ch);
    txStb <= 1'b1;
    txSpecial <= sp;
    txChar <= ch;
    @(posedge mclk);
  endtask
  task automatic txf(input logic [7:0] c, input logic ab);
    tx(1'b0, c);
    repeat (5) tx(1'b0, 8'h01);
    if (ab) tx(1'b1, 8'(lfs_pkg::K_ABORT));
    tx(1'b1, 8'(lfs_pkg::K_FLAG));
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    wb(1'b0, lfs_pkg::A_CNT, 32'h0);
    chk("count after reset", q, 32'h0);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped read", q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, lfs_pkg::A_CTRL, 32'(ctlTab[i]));
      repeat (2) @(posedge mclk);
      chk("permissions", 32'({txCtlOk, txPrivOk, txAppOk}), 32'(okTab[i]));
    end
    wb(1'b1, lfs_pkg::A_CTRL, 32'h0a);
    repeat (11) i_peer.putc(1'b1, 8'(lfs_pkg::K_FLAG), 1'b0);
    i_peer.frame(8'h00, 6, 1'b1);
    i_peer.frame(8'h01, 6, 1'b1);
    i_peer.frame(8'h0c, 6, 1'b1);
    i_peer.rest();
    wb(1'b0, lfs_pkg::A_CNT, 32'h0);
    chk("receive count", 32'(q[7:0]), 32'h2);
    chk("accepted frames", nAcc, 2);
    chk("link resets", nLrst, 1);
    chk("acknowledges", nAck, 2);
    chk("forward permits", nFwd, 3);
    i_peer.putc(1'b1, 8'(lfs_pkg::K_ABORT), 1'b0);
    i_peer.putc(1'b1, 8'(lfs_pkg::K_FLAG), 1'b0);
    i_peer.rest();
    chk("abort after flag", 32'(lastErp), 32'(lfs_pkg::E_PROTO));
    for (int i = 0; i < 4; i++) begin
      i_peer.frame(eCtl[i], eLen[i], 1'b1);
      i_peer.rest();
      chk("recovery code", 32'(lastErp), 32'(eCode[i]));
    end
    wb(1'b0, lfs_pkg::A_STAT, 32'h0);
    eStat = 32'(1 << lfs_pkg::ST_PROTO | 1 << lfs_pkg::ST_SEQ | 1 << lfs_pkg::ST_REJ | 1 << lfs_pkg::ST_CTLRX);
    chk("status flags", q, eStat);
    wb(1'b1, lfs_pkg::A_STAT, 32'h3f);
    wb(1'b0, lfs_pkg::A_STAT, 32'h0);
    chk("status cleared", q, 32'h0);
    i_peer.frame(8'h0d, 6, 1'b1);
    i_peer.rest();
    chk("total resets", nTot, 1);
    wb(1'b1, lfs_pkg::A_CTRL, 32'h06);
    i_peer.frame(8'h02, 6, 1'b1);
    i_peer.rest();
    wb(1'b0, lfs_pkg::A_CNT, 32'h0);
    chk("count in privileged", 32'(q[7:0]), 32'h2);
    chk("discarded frames", nDis, 1);
    wb(1'b1, lfs_pkg::A_CTRL, 32'h2a);
    i_peer.frame(8'h0f, 6, 1'b1);
    i_peer.rest();
    chk("absolute resets", nAbs, 1);
    chk("self-test requests", nPost, 1);
    chk("total with absolute", nTot, 2);
    wb(1'b1, lfs_pkg::A_CTRL, 32'h0a);
    tx(1'b1, 8'(lfs_pkg::K_FLAG));
    txf(8'h00, 1'b0);
    txf(8'h0c, 1'b0);
    txf(8'h01, 1'b1);
    txStb <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("txFsn", 32'(txFsn), 32'h1);
    wb(1'b1, lfs_pkg::A_CTRL, 32'h0);
    wb(1'b0, lfs_pkg::A_CNT, 32'h0);
    chk("count when disabled", q, 32'h0);
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire

/* core/lfs_framer.sv */
// Frame delimiting, control byte decoding and sequence counting for one port.
// Assumes decoded characters on the mclk domain and a Wishbone classic master.
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`default_nettype none
module lfs_framer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rxStb,
  input wire logic rxSpecial,
  input wire logic [7:0] rxChar,
  input wire logic rxCrcGood,
  input wire logic txStb,
  input wire logic txSpecial,
  input wire logic [7:0] txChar,
  output logic [1:0] txFsn,
  output logic txCtlOk,
  output logic txPrivOk,
  output logic txAppOk,
  output logic erpReq,
  output logic [2:0] erpCode,
  output logic ackReq,
  output logic frameAccept,
  output logic frameDiscard,
  output logic fwdOk,
  output logic linkResetRx,
  output logic totalReset,
  output logic absoluteReset,
  output logic postReq
);
  // ----------------------------------------------------------------
  // Registers and sequence counters
  // ----------------------------------------------------------------
  lfs_pkg::lfs_port_t portState_r;
  lfs_pkg::lfs_mode_t mode_r;
  logic extDist_r, postEn_r;
  logic [lfs_pkg::ST_W-1:0] stat_r, statSet;
  logic [7:0] lastCtl_r;
  logic [2:0] lastErp_r;
  logic wbHit, wbWr;
  lfs_seq_if rxSeq();
  lfs_seq_if txSeq();

  lfs_seq_ctr rxCtr (.mclk(mclk), .nrst(nrst), .sq(rxSeq));
  lfs_seq_ctr txCtr (.mclk(mclk), .nrst(nrst), .sq(txSeq));

  assign wbHit = cyc_i && stb_i && !ack_o;
  assign wbWr = wbHit && we_i && sel_i[0];
  assign rxSeq.wide = extDist_r;
  assign txSeq.wide = extDist_r;
  assign rxSeq.clr = portState_r == lfs_pkg::PS_DISABLED;
  assign txSeq.clr = portState_r == lfs_pkg::PS_DISABLED;
  assign txFsn = txSeq.cnt[1:0];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= wbHit;
      dat_o <= 32'h0000_0000;
      if (wbHit && !we_i) begin
        case (adr_i)
          lfs_pkg::A_CTRL: dat_o <= {26'h0, postEn_r, extDist_r, 2'(mode_r), 2'(portState_r)};
          lfs_pkg::A_STAT: dat_o <= {26'h0, stat_r};
          lfs_pkg::A_CNT: dat_o <= {16'h0, txSeq.cnt, rxSeq.cnt};
          lfs_pkg::A_LAST: dat_o <= {21'h0, lastErp_r, lastCtl_r};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portState_r <= lfs_pkg::PS_DISABLED;
      mode_r <= lfs_pkg::MD_OFF;
      extDist_r <= 1'b0;
      postEn_r <= 1'b0;
    end else if (wbWr && adr_i == lfs_pkg::A_CTRL) begin
      portState_r <= lfs_pkg::lfs_port_t'(dat_i[lfs_pkg::CT_STATE +: 2]);
      mode_r <= lfs_pkg::lfs_mode_t'(dat_i[lfs_pkg::CT_MODE +: 2]);
      extDist_r <= dat_i[lfs_pkg::CT_EXT];
      postEn_r <= dat_i[lfs_pkg::CT_POWER_ON_SELF_TEST];
    end
  end

  // A new event wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stat_r <= lfs_pkg::STAT_RST;
    end else if (wbWr && adr_i == lfs_pkg::A_STAT) begin
      stat_r <= (stat_r & ~dat_i[lfs_pkg::ST_W-1:0]) | statSet;
    end else begin
      stat_r <= stat_r | statSet;
    end
  end

  // ----------------------------------------------------------------
  // Receive character sequence checks
  // ----------------------------------------------------------------
  logic [3:0] rk, pendK_r;
  logic pendV_r, ackAdj_r, rrAdj_r, inReadyCheck;
  logic pairDone, firstOfPair, pairBad, repeatBad, abortBad, idleBad, viol;
  logic plainFlag, abortEnd, inFrame;
  logic [3:0] flagRun_r;
  logic [7:0] dataCnt_r;

  assign rk = lfs_pkg::charKind(rxSpecial, rxChar);
  assign inFrame = dataCnt_r != 8'h00;
  assign inReadyCheck = portState_r == lfs_pkg::PS_READY || portState_r == lfs_pkg::PS_CHECK;
  assign pairDone = pendV_r && ((pendK_r == lfs_pkg::K_ABORT) ? rk == lfs_pkg::K_FLAG : rk == pendK_r);
  assign firstOfPair = !pairDone && (rk == lfs_pkg::K_ACK || rk == lfs_pkg::K_RR || rk == lfs_pkg::K_ABORT);
  assign pairBad = pendV_r && !pairDone;
  assign repeatBad = pairDone && ((pendK_r == lfs_pkg::K_ACK && ackAdj_r)
                                  || (pendK_r == lfs_pkg::K_RR && rrAdj_r));
  assign abortBad = firstOfPair && rk == lfs_pkg::K_ABORT && !inFrame;
  assign idleBad = !inFrame && inReadyCheck && flagRun_r < lfs_pkg::IDLE_FLAGS
                   && (rk == lfs_pkg::K_SAT || rk == lfs_pkg::K_USER
                       || (firstOfPair && rk != lfs_pkg::K_ABORT));
  assign viol = rxStb && (pairBad || repeatBad || abortBad || idleBad);
  assign abortEnd = rxStb && pairDone && pendK_r == lfs_pkg::K_ABORT;
  assign plainFlag = rxStb && rk == lfs_pkg::K_FLAG && !abortEnd;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pendV_r <= 1'b0;
      pendK_r <= lfs_pkg::K_FLAG;
      ackAdj_r <= 1'b0;
      rrAdj_r <= 1'b0;
    end else if (rxStb) begin
      pendV_r <= firstOfPair;
      pendK_r <= rk;
      ackAdj_r <= pairDone && pendK_r == lfs_pkg::K_ACK;
      rrAdj_r <= pairDone && pendK_r == lfs_pkg::K_RR;
    end
  end

  // The run restarts outside Ready and Check so a freshly entered Ready sees a full idle window.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flagRun_r <= 4'h0;
    end else if (!inReadyCheck) begin
      flagRun_r <= 4'h0;
    end else if (rxStb && rk == lfs_pkg::K_DATA) begin
      flagRun_r <= 4'h0;
    end else if (plainFlag && flagRun_r < lfs_pkg::IDLE_FLAGS) begin
      flagRun_r <= 4'(flagRun_r + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // Receive frame tracking and evaluation
  // ----------------------------------------------------------------
  logic [7:0] ctl_r, postCnt_r;
  logic pathDone_r;
  logic frameEnd, isCtl, lenBad, seqBad, rejBad, short, ok;
  logic [2:0] code;

  assign frameEnd = plainFlag && inFrame;
  assign isCtl = ctl_r[3:2] == lfs_pkg::FT_CTL;
  assign short = dataCnt_r < lfs_pkg::MIN_FRAME;
  assign seqBad = !isCtl && ctl_r[1:0] != rxSeq.cnt[1:0];
  assign rejBad = ctl_r[7:4] != 4'h0 || ctl_r[3:2] == lfs_pkg::FT_RSV
                  || (isCtl && ctl_r[1:0] == lfs_pkg::RT_RSV);

  always_comb begin
    lenBad = 1'b0;
    if (isCtl) begin
      case (ctl_r[1:0])
        lfs_pkg::RT_LINK: lenBad = !(dataCnt_r == lfs_pkg::LINK_RST_LEN
                                     || (extDist_r && dataCnt_r == lfs_pkg::EXT_RST_LEN));
        lfs_pkg::RT_TOTAL, lfs_pkg::RT_ABS: lenBad = !pathDone_r || postCnt_r != lfs_pkg::CRC_LEN;
        default: lenBad = 1'b0;
      endcase
    end
  end

  always_comb begin
    if (short) begin
      code = lfs_pkg::E_PROTO;
    end else if (!rxCrcGood) begin
      code = lfs_pkg::E_CRC;
    end else if (lenBad) begin
      code = lfs_pkg::E_REJ;
    end else if (seqBad) begin
      code = lfs_pkg::E_SEQ;
    end else if (rejBad) begin
      code = lfs_pkg::E_REJ;
    end else begin
      code = lfs_pkg::E_NONE;
    end
  end
  assign ok = code == lfs_pkg::E_NONE;

  // NUL and the other fillers leave every counter untouched.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dataCnt_r <= 8'h00;
      ctl_r <= 8'h00;
      pathDone_r <= 1'b0;
      postCnt_r <= 8'h00;
    end else if (plainFlag || abortEnd) begin
      dataCnt_r <= 8'h00;
      pathDone_r <= 1'b0;
      postCnt_r <= 8'h00;
    end else if (rxStb && rk == lfs_pkg::K_DATA) begin
      if (dataCnt_r != 8'hff) begin
        dataCnt_r <= 8'(dataCnt_r + 8'h01);
      end
      if (!inFrame) begin
        ctl_r <= rxChar;
      end else if (pathDone_r) begin
        postCnt_r <= 8'(postCnt_r + 8'h01);
      end else if (!rxChar[lfs_pkg::EXTEND_BIT]) begin
        pathDone_r <= 1'b1;
      end
    end
  end

  assign rxSeq.inc = frameEnd && ok && !isCtl
                     && !(ctl_r[3:2] == lfs_pkg::FT_APP && mode_r == lfs_pkg::MD_PRIV);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      erpReq <= 1'b0;
      erpCode <= lfs_pkg::E_NONE;
      ackReq <= 1'b0;
      frameAccept <= 1'b0;
      frameDiscard <= 1'b0;
      fwdOk <= 1'b0;
      linkResetRx <= 1'b0;
      totalReset <= 1'b0;
      absoluteReset <= 1'b0;
      postReq <= 1'b0;
    end else begin
      erpReq <= (viol && portState_r == lfs_pkg::PS_READY) || (frameEnd && !ok);
      erpCode <= (viol && portState_r == lfs_pkg::PS_READY) ? lfs_pkg::E_PROTO
                 : (frameEnd ? code : lfs_pkg::E_NONE);
      ackReq <= rxSeq.inc;
      frameAccept <= rxSeq.inc;
      frameDiscard <= frameEnd && ok && !isCtl && !rxSeq.inc;
      fwdOk <= frameEnd && (isCtl || !seqBad);
      linkResetRx <= frameEnd && ok && isCtl && ctl_r[1:0] == lfs_pkg::RT_LINK;
      totalReset <= frameEnd && ok && isCtl && (ctl_r[1:0] == lfs_pkg::RT_TOTAL
                                                || ctl_r[1:0] == lfs_pkg::RT_ABS);
      absoluteReset <= frameEnd && ok && isCtl && ctl_r[1:0] == lfs_pkg::RT_ABS;
      postReq <= frameEnd && ok && isCtl && ctl_r[1:0] == lfs_pkg::RT_ABS && postEn_r;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lastCtl_r <= 8'h00;
      lastErp_r <= lfs_pkg::E_NONE;
    end else if (frameEnd) begin
      lastCtl_r <= ctl_r;
      lastErp_r <= code;
    end
  end

  // ----------------------------------------------------------------
  // Transmit permissions and sequence tracking
  // ----------------------------------------------------------------
  logic [3:0] tk;
  logic [7:0] txCnt_r;
  logic [1:0] txType_r;
  logic txAbt_r, modeOk, txIll;

  assign tk = lfs_pkg::charKind(txSpecial, txChar);
  assign modeOk = mode_r == lfs_pkg::MD_PRIV || mode_r == lfs_pkg::MD_NORM;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txCtlOk <= 1'b0;
      txPrivOk <= 1'b0;
      txAppOk <= 1'b0;
    end else begin
      case (portState_r)
        lfs_pkg::PS_READY: begin
          txCtlOk <= modeOk;
          txPrivOk <= modeOk;
          txAppOk <= mode_r == lfs_pkg::MD_NORM;
        end
        lfs_pkg::PS_ENABLED, lfs_pkg::PS_CHECK: begin
          txCtlOk <= modeOk;
          txPrivOk <= 1'b0;
          txAppOk <= 1'b0;
        end
        default: begin
          txCtlOk <= 1'b0;
          txPrivOk <= 1'b0;
          txAppOk <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    case (txChar[3:2])
      lfs_pkg::FT_CTL: txIll = !txCtlOk;
      lfs_pkg::FT_APP: txIll = !txAppOk;
      default: txIll = !txPrivOk;
    endcase
  end

  // A frame sent anyway outside its permission is flagged, not blocked on the line.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txCnt_r <= 8'h00;
      txType_r <= lfs_pkg::FT_APP;
      txAbt_r <= 1'b0;
    end else if (txStb && tk == lfs_pkg::K_FLAG) begin
      txCnt_r <= 8'h00;
      txAbt_r <= 1'b0;
    end else if (txStb && tk == lfs_pkg::K_ABORT) begin
      txAbt_r <= 1'b1;
    end else if (txStb && tk == lfs_pkg::K_DATA) begin
      if (txCnt_r == 8'h00) begin
        txType_r <= txChar[3:2];
      end
      if (txCnt_r != 8'hff) begin
        txCnt_r <= 8'(txCnt_r + 8'h01);
      end
    end
  end

  assign txSeq.inc = txStb && tk == lfs_pkg::K_FLAG && txCnt_r != 8'h00
                     && !txAbt_r && txType_r != lfs_pkg::FT_CTL;

  always_comb begin
    statSet = '0;
    statSet[lfs_pkg::ST_PROTO] = erpReq && erpCode == lfs_pkg::E_PROTO;
    statSet[lfs_pkg::ST_CRC] = erpReq && erpCode == lfs_pkg::E_CRC;
    statSet[lfs_pkg::ST_SEQ] = erpReq && erpCode == lfs_pkg::E_SEQ;
    statSet[lfs_pkg::ST_REJ] = erpReq && erpCode == lfs_pkg::E_REJ;
    statSet[lfs_pkg::ST_TXILL] = txStb && tk == lfs_pkg::K_DATA && txCnt_r == 8'h00 && txIll;
    statSet[lfs_pkg::ST_CTLRX] = linkResetRx || totalReset;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_disabled_clears: assert property (portState_r == lfs_pkg::PS_DISABLED |=> rxSeq.cnt == 8'h00
    && txSeq.cnt == 8'h00) else $error("counters not cleared while disabled");
  a_tx_ctl_hold: assert property (txStb && tk == lfs_pkg::K_FLAG && txType_r == lfs_pkg::FT_CTL
    && portState_r != lfs_pkg::PS_DISABLED |=> $stable(txSeq.cnt)) else $error("tx count moved on control");
  a_tx_abort_hold: assert property (txStb && tk == lfs_pkg::K_FLAG && txAbt_r |=> $stable(txSeq.cnt))
    else $error("tx count moved on abort");
  a_rx_ctl_hold: assert property (frameEnd && isCtl |=> $stable(rxSeq.cnt))
    else $error("rx count moved on control frame");
  a_seq_mismatch: assert property (frameEnd && !short && rxCrcGood && !lenBad && seqBad
    |=> erpReq && erpCode == lfs_pkg::E_SEQ && !ackReq) else $error("sequence error not raised");
  a_pair_break: assert property (rxStb && pendV_r && pendK_r == lfs_pkg::K_ACK && rk == lfs_pkg::K_DATA
    && portState_r == lfs_pkg::PS_READY |=> erpReq && erpCode == lfs_pkg::E_PROTO)
    else $error("broken pair not flagged");
  a_proto_ready: assert property (erpReq && erpCode == lfs_pkg::E_PROTO && !$past(frameEnd)
    |-> $past(portState_r) == lfs_pkg::PS_READY) else $error("protocol error outside Ready");
  a_short_frame: assert property (frameEnd && dataCnt_r < lfs_pkg::MIN_FRAME |=> erpReq && !frameAccept)
    else $error("short frame accepted");
  a_app_in_priv: assert property (frameEnd && ctl_r[3:2] == lfs_pkg::FT_APP && mode_r == lfs_pkg::MD_PRIV
    |=> !frameAccept && !ackReq) else $error("application frame taken in privileged mode");
  a_reserved_type: assert property (frameEnd && ok == 1'b0 && !short && rxCrcGood && !lenBad && !seqBad
    && rejBad |=> erpCode == lfs_pkg::E_REJ) else $error("reserved type not rejected");
  a_abs_reset: assert property (absoluteReset |-> totalReset && !erpReq)
    else $error("absolute reset without total reset");
  a_wb_ack_drop: assert property (ack_o |=> !ack_o) else $error("ack held past one cycle");

  c_frame_ok: cover property (frameAccept ##1 !frameAccept [*1] ##[1:40] frameAccept);
  c_total_rst: cover property (totalReset);
  c_seq_err: cover property (erpReq && erpCode == lfs_pkg::E_SEQ);
  c_tx_wrap: cover property (txSeq.inc && txSeq.cnt[1:0] == 2'h3);
endmodule
`default_nettype wire

/* core/lfs_seq_ctr.sv */
// One frame sequence counter, two bits or eight with extended distance.
// Assumes the owner raises clr for as long as the port is disabled.
`default_nettype none
module lfs_seq_ctr (
  input wire logic mclk,
  input wire logic nrst,
  lfs_seq_if.owner sq
);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sq.cnt <= lfs_pkg::CNT_RST;
    end else if (sq.clr) begin
      sq.cnt <= lfs_pkg::CNT_RST;
    end else if (sq.inc) begin
      // Narrow mode keeps the upper bits at zero so a later widening starts clean.
      sq.cnt <= sq.wide ? 8'(sq.cnt + 8'h01) : {6'h00, 2'(sq.cnt[1:0] + 2'h1)};
    end
  end

  a_ctr_modulo: assert property (@(posedge mclk) disable iff (!nrst)
    sq.inc && !sq.clr && !sq.wide |=> sq.cnt[7:2] == 6'h00 && sq.cnt[1:0] == 2'($past(sq.cnt[1:0]) + 2'h1))
    else $error("narrow counter did not step modulo four");
endmodule
`default_nettype wire

/* pkg/lfs_pkg.sv */
// Constants, types and helpers shared by the link frame sequencing block.
// Assumes one character clock; characters arrive already decoded.
`default_nettype none
package lfs_pkg;
  // ----------------------------------------------------------------
  // Port states, modes and character kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PS_DISABLED, PS_ENABLED, PS_READY, PS_CHECK} lfs_port_t;
  typedef enum logic [1:0] {MD_OFF, MD_PRIV, MD_NORM} lfs_mode_t;
  localparam logic [3:0] K_FLAG = 4'h0;
  localparam logic [3:0] K_ACK = 4'h1;
  localparam logic [3:0] K_RR = 4'h2;
  localparam logic [3:0] K_ABORT = 4'h3;
  localparam logic [3:0] K_NUL = 4'h4;
  localparam logic [3:0] K_SAT = 4'h5;
  localparam logic [3:0] K_USER = 4'h6;
  localparam logic [3:0] K_DIS = 4'h7;
  localparam logic [3:0] K_DATA = 4'h8;
  // ----------------------------------------------------------------
  // Control byte layout and encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FT_APP = 2'h0;
  localparam logic [1:0] FT_RSV = 2'h1;
  localparam logic [1:0] FT_PRIV = 2'h2;
  localparam logic [1:0] FT_CTL = 2'h3;
  localparam logic [1:0] RT_LINK = 2'h0;
  localparam logic [1:0] RT_TOTAL = 2'h1;
  localparam logic [1:0] RT_RSV = 2'h2;
  localparam logic [1:0] RT_ABS = 2'h3;
  localparam int EXTEND_BIT = 7;
  localparam logic [7:0] MIN_FRAME = 8'h06;
  localparam logic [7:0] LINK_RST_LEN = 8'h06;
  localparam logic [7:0] EXT_RST_LEN = 8'h07;
  localparam logic [7:0] CRC_LEN = 8'h04;
  localparam logic [3:0] IDLE_FLAGS = 4'ha;
  // ----------------------------------------------------------------
  // Recovery codes
  // ----------------------------------------------------------------
  localparam logic [2:0] E_NONE = 3'h0;
  localparam logic [2:0] E_PROTO = 3'h1;
  localparam logic [2:0] E_CRC = 3'h2;
  localparam logic [2:0] E_SEQ = 3'h3;
  localparam logic [2:0] E_REJ = 3'h4;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_STAT = 4'h4;
  localparam logic [3:0] A_CNT = 4'h8;
  localparam logic [3:0] A_LAST = 4'hc;
  localparam int CT_STATE = 0;
  localparam int CT_MODE = 2;
  localparam int CT_EXT = 4;
  localparam int CT_POWER_ON_SELF_TEST = 5;
  localparam int ST_PROTO = 0;
  localparam int ST_CRC = 1;
  localparam int ST_SEQ = 2;
  localparam int ST_REJ = 3;
  localparam int ST_TXILL = 4;
  localparam int ST_CTLRX = 5;
  localparam int ST_W = 6;
  localparam logic [ST_W-1:0] STAT_RST = 6'h00;
  localparam logic [7:0] CNT_RST = 8'h00;

  function automatic logic [3:0] charKind(input logic special, input logic [7:0] ch);
    charKind = special ? {1'b0, ch[2:0]} : K_DATA;
  endfunction
endpackage
`default_nettype wire

/* pkg/lfs_seq_if.sv */
// Carrier between the framer and one sequence counter.
// Assumes both ends share mclk.
`default_nettype none
interface lfs_seq_if;
  logic inc;
  logic clr;
  logic wide;
  logic [7:0] cnt;
  modport owner (input inc, input clr, input wide, output cnt);
  modport user (output inc, output clr, output wide, input cnt);
endinterface
`default_nettype wire
